// File: verilog/ris_pkg.sv
// package for the reset initialization sequencer
// assumes one 100 MHz clock and enables for the slower clock rates
package ris_pkg;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS     = 10;
   localparam int IN_ASSERT_CYCLES  = 32;
   localparam int POR_ASSERT_CYCLES = 32;
   localparam int OUT_ASSERT_CYCLES = 512;
   localparam int HARD_TO_SOFT_CYC  = 16;
   localparam int STRAP_OFF_NS      = 4;
   localparam int STRAP_OFF_CYCLES  = (STRAP_OFF_NS / CLK_PERIOD_NS) < 1 ?
                                      1 : (STRAP_OFF_NS / CLK_PERIOD_NS);
   localparam int STRAP_ON_CYCLES   = 1;
   localparam int PLL_LOCK_US       = 100;
   localparam int PLL_LOCK_CYCLES   = (PLL_LOCK_US * 1000) / CLK_PERIOD_NS;
   localparam int DLL_LOCK_MIN      = 7680;
   localparam int DLL_LOCK_MAX      = 122880;
   localparam int SYNC_DIV_DEFAULT  = 2;
   // ----------------------------------------------------------------
   // straps
   // ----------------------------------------------------------------
   localparam int BOOT_SRC_W        = 3;
   localparam logic [2:0] BOOT_SRC_RESET = 3'h0;
   typedef struct packed {
      logic [BOOT_SRC_W-1:0] bootSource;
      logic                  inputClockDivideStrap;
   } ris_strap_t;
   localparam int STRAP_W = BOOT_SRC_W + 1;
   typedef enum logic [2:0] {
      RIS_POR, RIS_PLL, RIS_DLL, RIS_HOLD, RIS_SOFT, RIS_RUN
   } ris_state_t;
endpackage : ris_pkg

// File: verilog/ris_filter.sv
// glitch filter for one active-low reset input
// assumes the input is already synchronous; counts on enable pulses
`timescale 1ns/1ps
`default_nettype none
module ris_filter
   import ris_pkg::*;
#(
   parameter int COUNT = 32
) (
   input  wire logic ref_clk,   // system clock
   input  wire logic reset_n,   // async reset, active low
   input  wire logic tick,      // counting clock enable
   input  wire logic pinLow_n,  // synchronised input, active low
   output logic      valid      // held long enough
);
   if (COUNT < 1) begin : g_bad_count
      $error("COUNT must be at least 1");
   end
   localparam int CW = $clog2(COUNT + 1);
   logic [CW-1:0] cnt;
   wire           atCount = (cnt == CW'(COUNT));
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt <= '0;
      end else if (pinLow_n) begin
         cnt <= '0;
      end else if (tick && !atCount) begin
         cnt <= cnt + CW'(1);
      end
   end
   assign valid = atCount;
endmodule : ris_filter
`default_nettype wire

// File: verilog/ris_sequencer.sv
// reset initialization sequencer: power-on, hard and soft reset
// assumes pins synchronous to ref_clk; open-drain pins split in/out/oe
//
// Summary of operation
// - Driven hard reset stays low at least 512 sync periods; a soft-only reset at least 16.
// - Hard reset released first, soft reset 16 sync periods later.
// - Strap pin drivers off within 4 ns of hard reset assertion; here only with the device's own pull, 32 sync periods into an external one.
// - Strap drivers resume at least 1 sync period after release.
// - Straps are a three-bit boot source and a clock divide strap.
// - In host mode sync clock period follows the divide strap.
// - Allow up to 100 us for PLL lock before trusting clocks.
// - Wait for DLL lock, 7680 to 122880 bus clock cycles.
// - Hard and soft reset pins only pull low or release.
`timescale 1ns/1ps
`default_nettype none
module ris_sequencer
   import ris_pkg::*;
#(
   parameter int PLL_CYCLES = PLL_LOCK_CYCLES,
   parameter int DLL_CYCLES = DLL_LOCK_MAX,
   parameter int SYNC_DIV   = SYNC_DIV_DEFAULT
) (
   input  wire logic       ref_clk,          // 100 MHz clock
   input  wire logic       reset_n,          // async reset, active low
   input  wire logic       hostMode,         // 1 host, 0 agent
   input  wire logic       primaryClockTick, // primary clock enable
   input  wire logic       busSyncTick,      // agent sync clock enable
   input  wire logic       power_on_reset_n, // power-on reset pin
   input  wire logic       pllLocked,        // pll lock status
   input  wire logic       dllLocked,        // dll lock status
   input  wire logic       hard_reset_n_in,  // hard reset pin level
   output logic            hard_reset_n_out, // hard reset drive value
   output logic            hard_reset_n_oe,  // hard reset pull enable
   input  wire logic       soft_reset_n_in,  // soft reset pin level
   output logic            soft_reset_n_out, // soft reset drive value
   output logic            soft_reset_n_oe,  // soft reset pull enable
   input  wire ris_strap_t strapIn,          // strap pin levels
   output ris_strap_t      strapLatched,     // straps caught at reset
   output logic            strapDriveEn,     // strap pins driven
   output logic            syncTick,         // bus sync clock enable
   output logic            pllTimeout,       // pll lock not seen
   output logic            dllTimeout,       // dll lock not seen
   output logic            sequenceDone      // device out of reset
);
   if (SYNC_DIV < 2 || SYNC_DIV % 2 != 0) begin : g_bad_div
      $error("SYNC_DIV must be even and at least 2");
   end
   // the dll floor must fit below the dll ceiling and in the counter
   if (PLL_CYCLES < 1 || DLL_CYCLES < DLL_LOCK_MIN) begin : g_bad_lock
      $error("lock wait counts out of range");
   end
   // ----------------------------------------------------------------
   // sync clock enable
   // ----------------------------------------------------------------
   localparam int DW = $clog2(SYNC_DIV * 2 + 1);
   logic [DW-1:0] divCnt;
   wire  [DW-1:0] divEnd = strapLatched.inputClockDivideStrap ?
                           DW'(SYNC_DIV * 2 - 1) : DW'(SYNC_DIV - 1);
   wire           divWrap = primaryClockTick && (divCnt >= divEnd);
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         divCnt <= '0;
      end else if (divWrap) begin
         divCnt <= '0;
      end else if (primaryClockTick) begin
         divCnt <= divCnt + DW'(1);
      end
   end
   assign syncTick = hostMode ? divWrap : busSyncTick;
   // ----------------------------------------------------------------
   // input filters
   // ----------------------------------------------------------------
   logic hardMeta, hardSync, softMeta, softSync, porMeta, porSync;
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         {hardMeta, hardSync, softMeta, softSync} <= 4'hF;
         {porMeta, porSync} <= 2'h0;
      end else begin
         {hardMeta, hardSync} <= {hard_reset_n_in, hardMeta};
         {softMeta, softSync} <= {soft_reset_n_in, softMeta};
         {porMeta, porSync}   <= {power_on_reset_n, porMeta};
      end
   end
   wire porTick = hostMode ? primaryClockTick : busSyncTick;
   logic hardReq, softReq, porValid;
   ris_filter #(.COUNT(IN_ASSERT_CYCLES)) uHard (
      .ref_clk(ref_clk), .reset_n(reset_n), .tick(syncTick),
      .pinLow_n(hardSync || hard_reset_n_oe), .valid(hardReq));
   ris_filter #(.COUNT(IN_ASSERT_CYCLES)) uSoft (
      .ref_clk(ref_clk), .reset_n(reset_n), .tick(syncTick),
      .pinLow_n(softSync || soft_reset_n_oe), .valid(softReq));
   ris_filter #(.COUNT(POR_ASSERT_CYCLES)) uPor (
      .ref_clk(ref_clk), .reset_n(reset_n), .tick(porTick),
      .pinLow_n(porSync), .valid(porValid));
   // ----------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------
   localparam int CNTW = $clog2(PLL_CYCLES + DLL_CYCLES +
                                OUT_ASSERT_CYCLES + 2);
   ris_state_t     state, next_state;
   logic [CNTW-1:0] cnt, next_cnt;
   logic           porSeen, next_porSeen;
   wire            porRelease = porSeen && porSync;
   wire            pllDone  = pllLocked || (cnt >= CNTW'(PLL_CYCLES - 1));
   wire            dllMinOk = cnt >= CNTW'(DLL_LOCK_MIN - 1);
   wire            dllDone  = (dllLocked && dllMinOk) ||
                              (cnt >= CNTW'(DLL_CYCLES - 1));
   // one tick beyond the period count, so whole periods are covered
   wire            holdDone = cnt > CNTW'(OUT_ASSERT_CYCLES);
   wire            softDone = cnt > CNTW'(HARD_TO_SOFT_CYC);
   always_comb begin
      next_state   = state;
      next_cnt     = cnt + CNTW'(1);
      next_porSeen = porSeen || porValid;
      unique case (state)
         RIS_POR: begin
            next_cnt = '0;
            if (porRelease) begin
               next_state = RIS_PLL;
            end
         end
         RIS_PLL: begin
            if (pllDone) begin
               next_state = RIS_DLL;
               next_cnt   = '0;
            end
         end
         RIS_DLL: begin
            if (dllDone) begin
               next_state = RIS_HOLD;
               next_cnt   = '0;
            end
         end
         RIS_HOLD: begin
            next_cnt = syncTick ? cnt + CNTW'(1) : cnt;
            if (holdDone) begin
               next_state = RIS_SOFT;
               next_cnt   = '0;
            end
         end
         RIS_SOFT: begin
            next_cnt = syncTick ? cnt + CNTW'(1) : cnt;
            if (softDone) begin
               next_state = RIS_RUN;
               next_cnt   = '0;
            end
         end
         RIS_RUN: begin
            next_cnt = syncTick && cnt == '0 ? CNTW'(1) : cnt;
            if (hardReq) begin
               next_state = RIS_HOLD;
               next_cnt   = '0;
            end else if (softReq) begin
               next_state = RIS_SOFT;
               next_cnt   = '0;
            end
         end
         default: next_state = RIS_POR;
      endcase
      if (!porSync) begin
         next_state = RIS_POR;
      end
      if (next_state == RIS_POR && state != RIS_POR) begin
         next_porSeen = porValid;
      end
   end
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state   <= RIS_POR;
         cnt     <= '0;
         porSeen <= 1'b0;
      end else begin
         state   <= next_state;
         cnt     <= next_cnt;
         porSeen <= next_porSeen;
      end
   end
   // ----------------------------------------------------------------
   // pins and straps
   // ----------------------------------------------------------------
   wire hardLow = state != RIS_SOFT && state != RIS_RUN;
   assign hard_reset_n_out = 1'b0;
   assign soft_reset_n_out = 1'b0;
   assign hard_reset_n_oe  = hardLow;
   assign soft_reset_n_oe  = state != RIS_RUN;
   assign strapDriveEn = state == RIS_RUN && cnt != '0;
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         strapLatched <= '{BOOT_SRC_RESET, 1'b0};
      // straps may settle late in power-on, so track until it ends
      end else if (state == RIS_POR) begin
         strapLatched <= strapIn;
      end
   end
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         pllTimeout <= 1'b0;
         dllTimeout <= 1'b0;
      end else begin
         if (state == RIS_POR) begin
            pllTimeout <= 1'b0;
            dllTimeout <= 1'b0;
         end
         if (state == RIS_PLL && pllDone && !pllLocked) begin
            pllTimeout <= 1'b1;
         end
         if (state == RIS_DLL && dllDone && !dllLocked) begin
            dllTimeout <= 1'b1;
         end
      end
   end
   assign sequenceDone = state == RIS_RUN;
endmodule : ris_sequencer
`default_nettype wire

// File: testbench/ris_sequencer_assertions.sv
// checker for the reset sequencer port behaviour
// assumes bound to ris_sequencer, pins sampled on ref_clk
`timescale 1ns/1ps
`default_nettype none
module ris_seq_assertions
   import ris_pkg::*;
(
   input wire logic       ref_clk,          // clock
   input wire logic       reset_n,          // async reset
   input wire logic       power_on_reset_n, // power-on pin
   input wire logic       hard_reset_n_out, // hard drive value
   input wire logic       hard_reset_n_oe,  // hard pull enable
   input wire logic       soft_reset_n_out, // soft drive value
   input wire logic       soft_reset_n_oe,  // soft pull enable
   input wire ris_strap_t strapLatched,     // caught straps
   input wire logic       strapDriveEn,     // strap drivers on
   input wire logic       syncTick,         // sync enable
   input wire logic       sequenceDone      // out of reset
);
   int holdCnt;
   int relCnt;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // ----------------------------------------------------------------
   // sync periods spent pulled and released
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         holdCnt <= 0;
         relCnt  <= 0;
      end else begin
         holdCnt <= hard_reset_n_oe ? holdCnt + int'(syncTick) : 0;
         relCnt  <= hard_reset_n_oe ? 0 : relCnt + int'(syncTick);
      end
   end
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   // n+1 ticks seen while pulled span at least n whole periods
   a_open_drain: assert property (
      !hard_reset_n_out && !soft_reset_n_out)
      else $error("reset pin driven high");
   a_hold_512: assert property (
      $fell(hard_reset_n_oe) |-> holdCnt > OUT_ASSERT_CYCLES)
      else $error("hard hold too short");
   a_hard_first: assert property (
      $fell(hard_reset_n_oe) |-> soft_reset_n_oe)
      else $error("soft released before hard");
   a_soft_gap: assert property (
      $fell(soft_reset_n_oe) |->
      !hard_reset_n_oe && relCnt > HARD_TO_SOFT_CYC)
      else $error("soft release too early");
   a_strap_off: assert property (
      hard_reset_n_oe |-> !strapDriveEn)
      else $error("straps driven in hard reset");
   a_strap_late: assert property (
      $rose(strapDriveEn) |-> relCnt > STRAP_ON_CYCLES)
      else $error("straps driven too soon");
   a_strap_frozen: assert property (
      $past(sequenceDone) && sequenceDone |-> $stable(strapLatched))
      else $error("straps changed in run");
   a_por_restart: assert property (
      $fell(power_on_reset_n) |-> ##[1:4] (hard_reset_n_oe && !sequenceDone))
      else $error("power-on reset ignored");
   a_done_free: assert property (
      sequenceDone |-> !hard_reset_n_oe && !soft_reset_n_oe)
      else $error("done in reset");
   c_soft_rel: cover property ($fell(soft_reset_n_oe));
   c_done: cover property ($rose(sequenceDone));
   c_strap_on: cover property ($rose(strapDriveEn));
endmodule : ris_seq_assertions
bind ris_sequencer ris_seq_assertions chk (.*);
`default_nettype wire

// File: testbench/ris_board.sv
// far side: board supervisor, strap resistors, reset wires
// assumes the bench calls por and pull between clock edges
`timescale 1ns/1ps
`default_nettype none
module ris_board
   import ris_pkg::*;
(
   input  wire logic ref_clk, // clock
   input  wire logic tick,    // power-on counting tick
   input  wire logic hardOe,  // device pulls hard reset
   input  wire logic softOe,  // device pulls soft reset
   input  wire logic drvEn,   // device drives straps
   output logic      porN,    // power-on reset pin
   output logic      hardLvl, // hard reset wire
   output logic      softLvl, // soft reset wire
   output ris_strap_t strap   // strap pin levels
);
   logic extHard = 1'b0;
   logic extSoft = 1'b0;
   initial porN = 1'b0;
   initial strap = '0;
   assign hardLvl = !(hardOe || extHard);
   assign softLvl = !(softOe || extSoft);
   always @(posedge drvEn) strap = ~strap;
   task automatic por(input int n, input ris_strap_t s);
      strap = ~s;
      porN  = 1'b0;
      repeat (n - 4) @(posedge ref_clk iff tick);
      @(negedge ref_clk);
      strap = s;
      // one spare tick keeps n whole periods after the pin synchroniser
      repeat (5) @(posedge ref_clk iff tick);
      @(negedge ref_clk);
      porN = 1'b1;
   endtask : por
   task automatic pull(input logic hard, input int n);
      extHard = hard;
      extSoft = !hard;
      repeat (n) @(negedge ref_clk);
      extHard = 1'b0;
      extSoft = 1'b0;
      // let the released wire be seen before the next pull
      repeat (4) @(negedge ref_clk);
   endtask : pull
endmodule : ris_board
`default_nettype wire

// File: testbench/reset_init_sequencer_tb.sv
// self-checking bench for the reset sequencer
// assumes ris_board as far side and the bound checker
`timescale 1ns/1ps
`default_nettype none
module reset_init_sequencer_tb;
   import ris_pkg::*;
   logic       ref_clk = 1'b0, reset_n = 1'b0, hostMode = 1'b1;
   logic       pTick = 1'b0, bTick = 1'b0, pll = 1'b0, dll = 1'b0;
   logic       porN, hardLvl, softLvl, hardOut, hardOe, softOut, softOe;
   logic       drvEn, sTick, pllTo, dllTo, done;
   ris_strap_t strap, latched;
   int         n_mismatch = 0, num_checks = 0, ph = 0, bPer = 3, w, per;
   int         seed = 32'h6fe237d1;
   localparam int PLL_TRY = 20;
   localparam int DLL_TRY = 7700;
   always #5 ref_clk = ~ref_clk;
   always @(negedge ref_clk) begin
      ph    <= ph + 1;
      pTick <= (ph % 2 == 0);
      bTick <= (ph % bPer == 0);
   end
   ris_sequencer #(.PLL_CYCLES(PLL_TRY), .DLL_CYCLES(DLL_TRY)) uut (
      .ref_clk, .reset_n, .hostMode, .primaryClockTick(pTick),
      .busSyncTick(bTick), .power_on_reset_n(porN), .pllLocked(pll),
      .dllLocked(dll), .hard_reset_n_in(hardLvl), .hard_reset_n_out(hardOut),
      .hard_reset_n_oe(hardOe), .soft_reset_n_in(softLvl),
      .soft_reset_n_out(softOut), .soft_reset_n_oe(softOe), .strapIn(strap),
      .strapLatched(latched), .strapDriveEn(drvEn), .syncTick(sTick),
      .pllTimeout(pllTo), .dllTimeout(dllTo), .sequenceDone(done));
   ris_board brd (.ref_clk, .tick(hostMode ? pTick : bTick), .hardOe,
      .softOe, .drvEn, .porN, .hardLvl, .softLvl, .strap);
   function automatic int expPer(input logic host, input logic div);
      return host ? 2 * SYNC_DIV_DEFAULT * (div ? 2 : 1) : bPer;
   endfunction : expPer
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk
   task automatic chkGe(input int got, input int lo);
      num_checks++;
      if (got < lo) begin
         n_mismatch++;
         $display("Error at %0t: got %0h below %0h", $time, got, lo);
      end
   endtask : chkGe
   task automatic waitSig(ref logic s, input logic v, output int n);
      for (n = 0; s !== v && n < 30000; n++) @(negedge ref_clk);
      if (s !== v) begin
         n_mismatch++;
         test_done();
      end
   endtask : waitSig
   task automatic boot(input logic host, input logic div, input logic lock);
      ris_strap_t s;
      s = {3'($random(seed)), div};
      hostMode = host;
      per = expPer(host, div);
      brd.por(32 + ($unsigned($random(seed)) % 9), s);
      chk({hardOe, softOe, drvEn, done}, 4'hC);
      repeat (5) @(negedge ref_clk);
      pll = lock;
      dll = lock;
      waitSig(done, 1'b1, w);
      chkGe(w, lock ? DLL_LOCK_MIN : DLL_TRY);
      chk({pllTo, dllTo}, {2{~lock}});
      chk({hardOut, softOut}, 2'h0);
      chk(latched, s);
      waitSig(sTick, 1'b1, w);
      @(negedge ref_clk);
      waitSig(sTick, 1'b1, w);
      chk(w + 1, per);
      brd.pull(1'b1, 20 * per);
      chk({hardOe, softOe}, 2'h0);
      brd.pull(1'b1, 40 * per);
      chk({hardOe, softOe, drvEn}, 3'h6);
      waitSig(hardOe, 1'b0, w);
      chkGe(w, 500 * per);
      waitSig(softOe, 1'b0, w);
      chkGe(w, 16 * per);
      brd.pull(1'b0, 40 * per);
      chk({hardOe, softOe}, 2'h1);
      waitSig(done, 1'b1, w);
      chk(latched, s);
      $display("boot done host %0d div %0d", host, div);
      pll = 1'b0;
      dll = 1'b0;
   endtask : boot
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : test_done
   initial begin
      repeat (12) @(negedge ref_clk);
      reset_n = 1'b1;
      chk({hardOe, softOe, drvEn, done, latched}, 8'hC0);
      boot(1'b1, 1'b0, 1'b1);
      boot(1'b1, 1'b1, 1'b1);
      // last boot never sees lock, so both waits run out
      boot(1'b0, 1'($random(seed)), 1'b0);
      test_done();
   end
endmodule : reset_init_sequencer_tb
`default_nettype wire
